// File: rtl/pts_pkg.sv
package pts_pkg;
	localparam int CLK_HZ = 40000000;
	localparam int TICK_MS = 10;
	localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
	localparam int TICK_W = 19;
	localparam int HOLD_MS = 2000;
	localparam int HOLD_TICKS = HOLD_MS / TICK_MS;
	localparam int IVL_W = 16;
	localparam int CNT_W = 8;
	localparam int ADR_W = 16;
	localparam int MBX_W = 12;
	localparam int DAT_W = 16;
	localparam int ROUTE_W = 64;
	localparam logic [CNT_W-1:0] MAX_COUNT = 8'h80;
	localparam logic [ADR_W-1:0] MBX_LO = 16'h0001;
	localparam logic [ADR_W-1:0] MBX_HI = 16'h0800;
	localparam int FIFO_DEPTH = 16;
	// message kind on the outgoing header
	localparam logic KIND_READ = 1'b0;
	localparam logic KIND_WRITE = 1'b1;
	typedef enum logic [1:0] {
		PTS_IDLE = 2'b00,
		PTS_WAIT = 2'b01,
		PTS_SEND = 2'b11,
		PTS_HOLD = 2'b10
	} pts_state_t;
endpackage

// File: rtl/pts_fifo.sv
`timescale 1ns/1ps
`default_nettype none
// small flop fifo, power-of-two depth
module pts_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [AW:0] wr_ff; // extra bit separates full from empty
	logic [AW:0] rd_ff;
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;
	assign in_ready = (wr_ff - rd_ff) != (AW+1)'(DEPTH);
	assign out_valid = wr_ff != rd_ff;
	assign out_data = mem_ff[rd_ff[AW-1:0]];
	// pointer update
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ff <= '0;
			rd_ff <= '0;
		end else begin
			if (push) wr_ff <= wr_ff + 1'b1;
			if (pop) rd_ff <= rd_ff + 1'b1;
		end
	end
	// storage has no reset; empty flag guards it
	always_ff @(posedge core_clk) begin
		if (push) mem_ff[wr_ff[AW-1:0]] <= in_data;
	end
endmodule
`default_nettype wire

// File: rtl/pts_top.sv
`timescale 1ns/1ps
`default_nettype none
// periodic transfer originator for one port
module pts_top
	import pts_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_n,
	// configuration
	input wire logic [IVL_W-1:0] cfg_interval,
	input wire logic [ROUTE_W-1:0] cfg_route,
	input wire logic [CNT_W-1:0] cfg_read_count,
	input wire logic [ADR_W-1:0] cfg_read_source,
	input wire logic [ADR_W-1:0] read_local_start,
	input wire logic [CNT_W-1:0] cfg_write_count,
	input wire logic [ADR_W-1:0] cfg_write_source,
	input wire logic [ADR_W-1:0] write_remote_start,
	input wire logic cfg_is_ethernet,
	input wire logic cfg_peer_share,
	input wire logic cfg_modbus_mode,
	// message request to the link engine
	output logic msg_valid,
	input wire logic msg_ready,
	output logic msg_kind,
	output logic [ROUTE_W-1:0] msg_route,
	output logic [ADR_W-1:0] msg_remote_addr,
	output logic [CNT_W-1:0] msg_count,
	input wire logic reply_done,
	// write data words read from mailbox
	output logic mbx_rd_en,
	output logic [MBX_W-1:0] mbx_rd_addr,
	input wire logic [DAT_W-1:0] mbx_rd_data,
	output logic wdat_valid,
	input wire logic wdat_ready,
	output logic [DAT_W-1:0] wdat_data,
	// read reply words into mailbox
	input wire logic rdat_valid,
	input wire logic [DAT_W-1:0] rdat_data,
	output logic mbx_wr_en,
	output logic [MBX_W-1:0] mbx_wr_addr,
	output logic [DAT_W-1:0] mbx_wr_data,
	// status
	output logic port_master,
	output logic busy
);
	// 10 ms tick divider
	logic [TICK_W-1:0] div_ff;
	logic tick_ff;
	// interval and hold counters in ticks
	logic [IVL_W-1:0] ivl_ff;
	logic [IVL_W-1:0] nxt_ivl;
	logic [IVL_W-1:0] hold_ff;
	pts_state_t state_ff;
	pts_state_t nxt_state;
	logic last_read_ff; // alternation memory
	logic pending_ff; // reply outstanding
	logic hold_req_ff; // two second wait armed
	logic [CNT_W-1:0] wleft_ff; // write words still to fetch
	logic [ADR_W-1:0] wptr_ff;
	logic fetch_ff; // mailbox read strobe out this cycle
	logic push_ff; // mailbox word stands now; push it into the fifo
	logic [ADR_W-1:0] rptr_ff;
	logic [CNT_W-1:0] rleft_ff;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic [DAT_W-1:0] fifo_out_data;

	// configuration checks
	wire read_ok = cfg_read_count != '0 && cfg_read_count <= MAX_COUNT
		&& read_local_start >= MBX_LO
		&& read_local_start <= MBX_HI;
	wire write_ok = cfg_write_count != '0
		&& cfg_write_count <= MAX_COUNT;
	wire peer_block = cfg_is_ethernet && cfg_peer_share;
	wire func_on = cfg_interval != '0 && !peer_block
		&& (read_ok || write_ok);
	// next type: alternate when both enabled, read first
	wire pick_write = write_ok && (!read_ok || last_read_ff);
	wire expired = tick_ff && (ivl_ff + 1'b1 >= cfg_interval);
	wire issue = state_ff == PTS_SEND && msg_ready;
	// the fifo input stalls the mailbox fetch, so fill is honest
	// one fetch in flight at a time, so the fifo can never overflow
	wire fetch_go = wleft_ff != '0 && fifo_in_ready && !fetch_ff && !push_ff;
	wire hold_done = tick_ff && hold_ff + 1'b1 >= IVL_W'(HOLD_TICKS);

	// tick divider: one-cycle enable every 10 ms
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			div_ff <= '0;
			tick_ff <= 1'b0;
		end else begin
			tick_ff <= div_ff == TICK_W'(TICK_CYC - 1);
			div_ff <= (div_ff == TICK_W'(TICK_CYC - 1)) ? '0 : div_ff + 1'b1;
		end
	end

	// state sequencing
	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			PTS_IDLE: begin
				if (func_on) nxt_state = PTS_WAIT;
			end
			PTS_WAIT: begin
				if (!func_on) nxt_state = PTS_IDLE;
				else if (expired && pending_ff) nxt_state = PTS_HOLD;
				else if (expired) nxt_state = PTS_SEND;
			end
			PTS_HOLD: begin
				if (!func_on) nxt_state = PTS_IDLE;
				else if (hold_done) nxt_state = PTS_SEND;
			end
			PTS_SEND: begin
				if (issue) nxt_state = PTS_WAIT;
			end
		endcase
	end

	// interval restarts on every issue, cleared while idle
	always_comb begin
		nxt_ivl = ivl_ff;
		if (state_ff != PTS_WAIT) nxt_ivl = '0;
		else if (tick_ff) nxt_ivl = ivl_ff + 1'b1;
	end

	// control registers
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= PTS_IDLE;
			ivl_ff <= '0;
			hold_ff <= '0;
			last_read_ff <= 1'b0;
			hold_req_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			ivl_ff <= nxt_ivl;
			hold_ff <= (state_ff == PTS_HOLD && tick_ff) ? hold_ff + 1'b1
				: (state_ff == PTS_HOLD ? hold_ff : '0);
			hold_req_ff <= state_ff == PTS_HOLD;
			if (issue) last_read_ff <= (msg_kind == KIND_READ);
			if (state_ff == PTS_IDLE) last_read_ff <= 1'b0; // reads go first
		end
	end

	// reply tracking; a reply in the issue cycle belongs to the old message
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pending_ff <= 1'b0;
		end else if (issue) begin
			pending_ff <= 1'b1;
		end else if (reply_done || state_ff == PTS_IDLE) begin
			pending_ff <= 1'b0;
		end
	end

	// message header, held steady while presented
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			msg_valid <= 1'b0;
			msg_kind <= KIND_READ;
			msg_route <= '0;
			msg_remote_addr <= '0;
			msg_count <= '0;
		end else if (nxt_state == PTS_SEND && state_ff != PTS_SEND) begin
			msg_valid <= 1'b1;
			msg_route <= cfg_route;
			msg_kind <= pick_write ? KIND_WRITE : KIND_READ;
			msg_remote_addr <= pick_write ? write_remote_start
				: cfg_read_source;
			msg_count <= pick_write ? cfg_write_count : cfg_read_count;
		end else if (issue) begin
			msg_valid <= 1'b0;
		end
	end

	// write data fetch from consecutive mailbox registers
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			wleft_ff <= '0;
			wptr_ff <= '0;
			fetch_ff <= 1'b0;
			push_ff <= 1'b0;
			mbx_rd_en <= 1'b0;
			mbx_rd_addr <= '0;
		end else begin
			fetch_ff <= fetch_go;
			// mailbox data stands the cycle after the read strobe
			push_ff <= fetch_ff;
			mbx_rd_en <= fetch_go;
			if (issue && msg_kind == KIND_WRITE) begin
				wleft_ff <= msg_count;
				wptr_ff <= cfg_write_source;
			end else if (fetch_go) begin
				wleft_ff <= wleft_ff - 1'b1;
				wptr_ff <= wptr_ff + 1'b1;
				mbx_rd_addr <= wptr_ff[MBX_W-1:0];
			end
		end
	end

	// outgoing write words buffered for the link
	pts_fifo #(.WIDTH(DAT_W), .DEPTH(FIFO_DEPTH)) u_wfifo (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.in_valid(push_ff),
		.in_ready(fifo_in_ready),
		.in_data(mbx_rd_data),
		.out_valid(fifo_out_valid),
		.out_ready(wdat_ready || !wdat_valid),
		.out_data(fifo_out_data)
	);

	// output stage register for write data
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			wdat_valid <= 1'b0;
			wdat_data <= '0;
		end else if (wdat_ready || !wdat_valid) begin
			wdat_valid <= fifo_out_valid;
			wdat_data <= fifo_out_data;
		end
	end

	// read reply words land in the mailbox
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rptr_ff <= '0;
			rleft_ff <= '0;
			mbx_wr_en <= 1'b0;
			mbx_wr_addr <= '0;
			mbx_wr_data <= '0;
		end else begin
			mbx_wr_en <= rdat_valid && rleft_ff != '0;
			if (issue && msg_kind == KIND_READ) begin
				rptr_ff <= read_local_start;
				rleft_ff <= msg_count;
			end else if (rdat_valid && rleft_ff != '0) begin
				mbx_wr_addr <= rptr_ff[MBX_W-1:0];
				mbx_wr_data <= rdat_data;
				rptr_ff <= rptr_ff + 1'b1;
				rleft_ff <= rleft_ff - 1'b1;
			end
		end
	end

	// status outputs
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			port_master <= 1'b0;
			busy <= 1'b0;
		end else begin
			port_master <= cfg_modbus_mode && func_on;
			busy <= pending_ff || hold_req_ff;
		end
	end
endmodule
`default_nettype wire

// File: sim/pts_props.sv
`timescale 1ns/1ps
`default_nettype none
// port checks of the originator
module pts_props
	import pts_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [IVL_W-1:0] cfg_interval,
	input wire logic [ROUTE_W-1:0] cfg_route,
	input wire logic [ADR_W-1:0] cfg_read_source,
	input wire logic [ADR_W-1:0] write_remote_start,
	input wire logic cfg_modbus_mode,
	input wire logic msg_valid,
	input wire logic msg_ready,
	input wire logic msg_kind,
	input wire logic [ROUTE_W-1:0] msg_route,
	input wire logic [ADR_W-1:0] msg_remote_addr,
	input wire logic rdat_valid,
	input wire logic [DAT_W-1:0] rdat_data,
	input wire logic mbx_wr_en,
	input wire logic [DAT_W-1:0] mbx_wr_data,
	input wire logic port_master
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	a_zero_ivl_quiet: assert property (
		!msg_valid && cfg_interval == 16'h0000 |=> !msg_valid) else $error("zero");
	a_zero_no_master: assert property (
		cfg_interval == 16'h0000 && $past(cfg_interval) == 16'h0000
		|-> !port_master) else $error("master on");
	a_route_fixed: assert property (
		msg_valid |-> msg_route == cfg_route) else $error("route");
	a_read_source: assert property (
		msg_valid && msg_kind == KIND_READ
		|-> msg_remote_addr == cfg_read_source) else $error("read");
	a_write_dest: assert property (
		msg_valid && msg_kind == KIND_WRITE
		|-> msg_remote_addr == write_remote_start) else $error("write");
	a_req_holds: assert property (
		msg_valid && !msg_ready |=> msg_valid && $stable(msg_kind)
		&& $stable(msg_remote_addr)) else $error("hold");
	a_mbx_fill: assert property (
		mbx_wr_en |-> $past(rdat_valid) && mbx_wr_data == $past(rdat_data))
		else $error("fill");
	a_master_mode: assert property (
		$rose(port_master) |-> $past(cfg_modbus_mode)) else $error("master");
endmodule
bind pts_top pts_props u_props (.*);
`default_nettype wire

// File: sim/pts_far_model.sv
`timescale 1ns/1ps
`default_nettype none
// far link engine: one message at a time, random stalls
module pts_far_model
	import pts_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic msg_valid,
	input wire logic msg_kind,
	input wire logic [CNT_W-1:0] msg_count,
	output logic msg_ready,
	output logic reply_done,
	input wire logic mbx_rd_en,
	input wire logic [MBX_W-1:0] mbx_rd_addr,
	output logic [DAT_W-1:0] mbx_rd_data,
	input wire logic wdat_valid,
	output logic wdat_ready,
	output logic rdat_valid,
	output logic [DAT_W-1:0] rdat_data
);
	logic act_ff, kind_ff; // message in flight and its kind
	logic [CNT_W-1:0] left_ff; // words still to move
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			{msg_ready, reply_done, wdat_ready, rdat_valid} <= 4'h0;
			{act_ff, kind_ff, left_ff} <= 10'h000;
			{mbx_rd_data, rdat_data} <= 32'h0000_0000;
		end else begin
			// stale words are scrambled, never held
			mbx_rd_data <= mbx_rd_en ? {4'hA, mbx_rd_addr} : ~mbx_rd_data;
			rdat_data <= ~rdat_data;
			reply_done <= 1'h0;
			rdat_valid <= 1'h0;
			wdat_ready <= $urandom % 4 == 0; // long stalls fill the fifo
			msg_ready <= msg_valid && !msg_ready && !act_ff && $urandom % 2 == 1;
			if (msg_valid && msg_ready) begin
				{act_ff, kind_ff, left_ff} <= {1'h1, msg_kind, msg_count};
			end else if (act_ff && left_ff == 8'h00) begin
				act_ff <= 1'h0;
				reply_done <= 1'h1;
			end else if (act_ff && !kind_ff && $urandom % 2 == 1) begin
				rdat_valid <= 1'h1;
				rdat_data <= 16'h5000 + {8'h00, left_ff};
				left_ff <= left_ff - 8'h01;
			end else if (act_ff && wdat_valid && wdat_ready) begin
				left_ff <= left_ff - 8'h01;
			end
		end
	end
endmodule
`default_nettype wire

// File: sim/pts_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module pts_top_tb_top
	import pts_pkg::*;
;
	logic core_clk, rst_n, msg_valid, msg_ready, msg_kind, reply_done, busy;
	logic cfg_is_ethernet, cfg_peer_share, cfg_modbus_mode, port_master;
	logic mbx_rd_en, wdat_valid, wdat_ready, rdat_valid, mbx_wr_en, vq;
	logic [IVL_W-1:0] cfg_interval;
	logic [ROUTE_W-1:0] cfg_route, msg_route;
	logic [CNT_W-1:0] cfg_read_count, cfg_write_count, msg_count;
	logic [ADR_W-1:0] cfg_read_source, read_local_start, cfg_write_source;
	logic [ADR_W-1:0] write_remote_start, msg_remote_addr;
	logic [MBX_W-1:0] mbx_rd_addr, mbx_wr_addr;
	logic [DAT_W-1:0] mbx_rd_data, wdat_data, rdat_data, mbx_wr_data;
	int error_cnt = 0, tests_run = 0, cyc = 0, rc, n;
	int tq[$];
	logic [31:0] kq[$], aq[$], wq[$], dq[$];
	pts_top uut (.*);
	pts_far_model far (.*);
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		tests_run++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD %0t got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic stop_test();
		$display("%0d bad of %0d", error_cnt, tests_run);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	initial begin
		core_clk = 1'h0;
		forever #12.5 core_clk = ~core_clk;
	end
	// log request starts, kinds, mailbox stores and outgoing words
	always @(posedge core_clk) begin
		cyc++;
		if (msg_valid && !vq) tq.push_back(cyc);
		vq = msg_valid;
		if (msg_valid && msg_ready) kq.push_back(32'(msg_kind));
		if (mbx_wr_en) aq.push_back(32'(mbx_wr_addr));
		if (mbx_wr_en) dq.push_back(32'(mbx_wr_data));
		if (wdat_valid && wdat_ready) wq.push_back(32'(wdat_data));
	end
	initial begin
		void'($urandom(19));
		rst_n = 1'h0;
		cfg_interval = 16'h0000;
		cfg_route = {$urandom, $urandom};
		cfg_read_count = 8'($urandom % 8 + 1);
		cfg_read_source = 16'($urandom);
		read_local_start = 16'h0800; // top mailbox register
		cfg_write_count = 8'($urandom % 16 + 20); // more than the fifo holds
		cfg_write_source = 16'($urandom);
		write_remote_start = 16'($urandom);
		cfg_is_ethernet = 1'h0;
		cfg_peer_share = 1'h0;
		cfg_modbus_mode = 1'h1;
		repeat (6) @(negedge core_clk);
		rst_n = 1'h1;
		repeat (300) @(negedge core_clk);
		check(port_master, 1'h0);
		cfg_interval = 16'h0001; // ten ms dwarfs a message
		for (n = 0; n < 1300000 && kq.size() < 3; n++) @(negedge core_clk);
		repeat (3000) @(negedge core_clk);
		check(port_master, 1'h1);
		check(kq.size(), 3);
		if (kq.size() >= 3 && tq.size() >= 3) begin
			for (n = 0; n < 3; n++) check(kq[n], n % 2);
			check(tq[1] - tq[0], TICK_CYC);
			check(tq[2] - tq[1], TICK_CYC);
		end
		rc = cfg_read_count;
		check(aq.size(), 2 * rc);
		foreach (aq[i]) check(aq[i], 12'h800 + 12'(i % rc));
		check(dq.size(), 2 * rc);
		foreach (dq[i]) check(dq[i], 32'h5000 + rc - i % rc);
		check(wq.size(), cfg_write_count);
		foreach (wq[i]) check(wq[i], {4'hA, cfg_write_source[11:0] + 12'(i)});
		// peer sharing on the ethernet port switches the function off
		cfg_is_ethernet = 1'h1;
		cfg_peer_share = 1'h1;
		repeat (20) @(negedge core_clk);
		check(port_master, 1'h0);
		check(msg_valid, 1'h0);
		cfg_peer_share = 1'h0;
		cfg_is_ethernet = 1'h0;
		cfg_interval = 16'h0000;
		repeat (20) @(negedge core_clk);
		check(port_master, 1'h0);
		check(busy, 1'h0);
		stop_test();
	end
endmodule
`default_nettype wire
